// [xcall_move.sv]
// Notes on behaviour
// RULE_01: computed call pushes PC plus two in the same clock as the counter load
// RULE_02: working register replaces counter low byte
// RULE_03: latches load counter high and upper bytes
// RULE_04: computed call takes two cycles, second idle
// RULE_05: computed call saves no shadow registers
// RULE_06: source is stack pointer plus 7-bit offset
// RULE_07: destination is 12-bit second-word field
// RULE_08: both addresses span full 4096-byte space
// RULE_09: software avoids counter low, stack top destinations
// RULE_10: indirect register source reads as zero
// RULE_11: neither instruction touches status flags
`default_nettype none
module xcall_move #(
  parameter int ADDR_W = 12          // data space address width
) (
  input  wire logic              SYS_CLK_IN,
  input  wire logic              RST_B_IN,
  input  wire logic              CYCLE_EN_IN,      // one pulse per instruction cycle
  input  wire logic [15:0]       INSTR_IN,         // fetched instruction word
  input  wire logic [20:0]       PC_IN,            // address of current instruction
  input  wire logic [7:0]        WORKING_REG_IN,
  input  wire logic [7:0]        LATCH_HIGH_IN,
  input  wire logic [7:0]        LATCH_UPPER_IN,
  input  wire logic [ADDR_W-1:0] SOFT_SP_IN,       // software stack pointer
  input  wire logic [7:0]        MEM_RDATA_IN,     // data memory read byte
  output logic                   PUSH_OUT,         // push pulse to return stack
  output logic [20:0]            PUSH_ADDR_OUT,
  output logic                   PC_LOAD_OUT,      // load pulse for program counter
  output logic [20:0]            PC_VALUE_OUT,
  output logic                   FLUSH_OUT,        // second cycle is a forced nop
  output logic [ADDR_W-1:0]      MEM_ADDR_OUT,
  output logic                   MEM_RD_OUT,
  output logic                   MEM_WR_OUT,
  output logic [7:0]             MEM_WDATA_OUT,
  output logic                   BUSY_OUT          // instruction word owned by this block
);

  // whole state in one record
  typedef struct packed {
    xcall_move_pkg::state_t st;
    logic                   push;
    logic [20:0]            push_addr;
    logic                   pc_load;
    logic [20:0]            pc_value;
    logic                   flush;
    logic [ADDR_W-1:0]      addr;
    logic                   rd;
    logic                   wr;
    logic [7:0]             wdata;
  } regs_t;

  regs_t s_q;     // registered state
  regs_t s_d;     // next state

  // source address decodes into the indirect window; these registers
  // have no byte of their own to give, so a move from them yields zero
  function automatic logic is_indirect(input logic [ADDR_W-1:0] a);
    is_indirect = (a >= ADDR_W'(xcall_move_pkg::INDIRECT_FIRST)) &&
                  (a <= ADDR_W'(xcall_move_pkg::INDIRECT_LAST));
  endfunction

  // decode of the word on the bus, meaningful only in an enabled cycle
  logic is_call;          // single word call opcode
  logic is_move;          // first word of the move
  logic [ADDR_W-1:0] src; // computed source address

  assign is_call = (INSTR_IN == xcall_move_pkg::CALL_OPCODE);
  assign is_move = (INSTR_IN[15:7] == xcall_move_pkg::MOVE_W1_PREFIX);
  // wraps within the data space, so every byte is reachable
  assign src = ADDR_W'(SOFT_SP_IN + ADDR_W'(INSTR_IN[xcall_move_pkg::OFFSET_W-1:0])); // RULE_06 RULE_08

  // next state, stepped once per instruction cycle enable;
  // pulses drop on every clock so each lasts exactly one clock,
  // while addresses and data hold until the next update
  always_comb begin
    s_d       = s_q;
    s_d.push  = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.rd    = 1'b0;
    s_d.wr    = 1'b0;
    // nothing advances between enables, so flush covers a whole cycle
    if (CYCLE_EN_IN) begin
      s_d.flush = 1'b0;
      case (s_q.st)
        // first cycle of either instruction
        xcall_move_pkg::ST_IDLE: begin
          if (is_call) begin
            // return address goes out in the same clock as the counter load pulse
            s_d.push      = 1'b1;                                   // RULE_01
            s_d.push_addr = 21'(PC_IN + xcall_move_pkg::PC_STEP);   // RULE_01
            s_d.pc_load   = 1'b1;
            // old low byte dropped; latches form the upper bytes
            s_d.pc_value  = {LATCH_UPPER_IN[4:0], LATCH_HIGH_IN, WORKING_REG_IN}; // RULE_02 RULE_03
            s_d.st        = xcall_move_pkg::ST_CALL;
            // no shadow copy of working, flag or bank select registers;
            // a caller that needs them saves them itself          RULE_05
          end else if (is_move) begin
            s_d.addr = src;                                         // RULE_06
            s_d.rd   = 1'b1;
            s_d.st   = xcall_move_pkg::ST_MOVE;
          end
        end
        // forced nop while the new target word is fetched
        xcall_move_pkg::ST_CALL: begin
          s_d.flush = 1'b1;                                         // RULE_04
          s_d.st    = xcall_move_pkg::ST_IDLE;
        end
        // second move cycle; a word without the 1111 prefix writes nothing
        xcall_move_pkg::ST_MOVE: begin
          // second word carries the 12-bit destination
          s_d.addr  = ADDR_W'(INSTR_IN[xcall_move_pkg::DEST_W-1:0]); // RULE_07 RULE_08
          s_d.wr    = (INSTR_IN[15:12] == xcall_move_pkg::MOVE_W2_PREFIX); // RULE_07
          // indirect register reads give zero
          s_d.wdata = is_indirect(s_q.addr) ? xcall_move_pkg::INDIRECT_VALUE
                                            : MEM_RDATA_IN;        // RULE_10
          s_d.st    = xcall_move_pkg::ST_IDLE;
        end
        // unused code: fall back to idle rather than hang
        default: s_d.st = xcall_move_pkg::ST_IDLE;
      endcase
    end
  end

  // state register
  // async clear leaves every output at its idle level
  always_ff @(posedge SYS_CLK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state record; only busy is decoded from the state
  assign PUSH_OUT      = s_q.push;
  assign PUSH_ADDR_OUT = s_q.push_addr;
  assign PC_LOAD_OUT   = s_q.pc_load;
  assign PC_VALUE_OUT  = s_q.pc_value;
  assign FLUSH_OUT     = s_q.flush;
  assign MEM_ADDR_OUT  = s_q.addr;
  assign MEM_RD_OUT    = s_q.rd;
  assign MEM_WR_OUT    = s_q.wr;
  assign MEM_WDATA_OUT = s_q.wdata;
  assign BUSY_OUT      = (s_q.st != xcall_move_pkg::ST_IDLE);
  // status flags have no path out of this block                  RULE_11
  // destination checks for counter/stack bytes left to software   RULE_09

  // checks run on the system clock and sleep while reset is held
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RST_B_IN);

  // computed call
  // the return address leaves together with the push pulse
  a_push_addr_value: assert property ( // RULE_01
    (CYCLE_EN_IN && !BUSY_OUT && is_call) |=>
    PUSH_OUT && PUSH_ADDR_OUT == 21'($past(PC_IN) + xcall_move_pkg::PC_STEP))
    else $error("push address wrong");
  // low byte is the working register, the old low byte is gone
  a_pc_low_byte: assert property ( // RULE_02
    (CYCLE_EN_IN && !BUSY_OUT && is_call) |=>
    PC_LOAD_OUT && PC_VALUE_OUT[7:0] == $past(WORKING_REG_IN))
    else $error("pc low byte wrong");
  // both latches land in the upper part of the counter
  a_pc_upper_bytes: assert property ( // RULE_03
    (CYCLE_EN_IN && !BUSY_OUT && is_call) |=>
    PC_VALUE_OUT[15:8] == $past(LATCH_HIGH_IN) &&
    PC_VALUE_OUT[20:16] == $past(LATCH_UPPER_IN[4:0]))
    else $error("pc upper bytes wrong");
  // the next enabled edge is the nop cycle, after it the block is idle
  a_call_two_cycles: assert property ( // RULE_04
    (CYCLE_EN_IN && s_q.st == xcall_move_pkg::ST_CALL) |=>
    FLUSH_OUT && !BUSY_OUT && !PUSH_OUT && !PC_LOAD_OUT)
    else $error("call second cycle missing");
  // without an enable the call keeps its first cycle
  a_call_waits: assert property ( // RULE_04
    (!CYCLE_EN_IN && s_q.st == xcall_move_pkg::ST_CALL) |=>
    BUSY_OUT && !FLUSH_OUT && !PC_LOAD_OUT)
    else $error("call left its first cycle early");
  // a push comes only with the load and never with a data access
  a_push_with_load: assert property ( // RULE_05
    PUSH_OUT |-> PC_LOAD_OUT && !MEM_WR_OUT && !MEM_RD_OUT)
    else $error("push without load");

  // indexed move
  // source is pointer plus offset, wrapped into the data space
  a_source_addr: assert property ( // RULE_06
    (CYCLE_EN_IN && !BUSY_OUT && !is_call && is_move) |=>
    MEM_RD_OUT && MEM_ADDR_OUT == ADDR_W'($past(SOFT_SP_IN) + ADDR_W'($past(INSTR_IN[6:0]))))
    else $error("source address wrong");
  // a write goes to the 12-bit field of a well-formed second word
  a_dest_addr: assert property ( // RULE_07
    MEM_WR_OUT |-> MEM_ADDR_OUT == ADDR_W'($past(INSTR_IN[11:0])) &&
    $past(INSTR_IN[15:12]) == xcall_move_pkg::MOVE_W2_PREFIX)
    else $error("destination address wrong");
  // a second word without the prefix is dropped
  a_move_refused: assert property ( // RULE_07
    (CYCLE_EN_IN && s_q.st == xcall_move_pkg::ST_MOVE &&
     INSTR_IN[15:12] != xcall_move_pkg::MOVE_W2_PREFIX) |=> !MEM_WR_OUT)
    else $error("malformed second word wrote");
  // an ordinary source byte is passed through unchanged
  a_move_data: assert property ( // RULE_07
    (CYCLE_EN_IN && s_q.st == xcall_move_pkg::ST_MOVE && !is_indirect(MEM_ADDR_OUT)) |=>
    MEM_WDATA_OUT == $past(MEM_RDATA_IN))
    else $error("moved byte wrong");
  // a source in the indirect window gives zero
  a_indirect_zero: assert property ( // RULE_10
    (CYCLE_EN_IN && s_q.st == xcall_move_pkg::ST_MOVE && is_indirect(MEM_ADDR_OUT)) |=>
    MEM_WDATA_OUT == xcall_move_pkg::INDIRECT_VALUE)
    else $error("indirect source not zero");
  // the two cycles of the move never touch memory twice at once
  a_no_read_write: assert property (!(MEM_RD_OUT && MEM_WR_OUT)) // RULE_11
    else $error("read and write together");

  // main scenarios reached by the bench
  c_call: cover property (PC_LOAD_OUT ##[1:8] FLUSH_OUT);
  c_move: cover property (MEM_RD_OUT ##[1:8] MEM_WR_OUT);
  c_move_indirect: cover property (MEM_WR_OUT && MEM_WDATA_OUT == 8'h00);
  c_move_wrap: cover property (MEM_RD_OUT && MEM_ADDR_OUT < SOFT_SP_IN);
  c_move_refused: cover property ((CYCLE_EN_IN && s_q.st == xcall_move_pkg::ST_MOVE) ##1 !MEM_WR_OUT);
endmodule
`default_nettype wire

// [xcall_move_pkg.sv]
`default_nettype none
package xcall_move_pkg;
  // opcode patterns
  localparam logic [15:0] CALL_OPCODE     = 16'h0014;
  localparam logic [8:0]  MOVE_W1_PREFIX  = 9'h1D6;   // 1110_1011_0 in bits 15:7
  localparam logic [3:0]  MOVE_W2_PREFIX  = 4'hF;
  // field positions
  localparam int          OFFSET_LSB      = 0;
  localparam int          OFFSET_W        = 7;
  localparam int          DEST_W          = 12;
  // indirect-access register window in data space
  localparam logic [11:0] INDIRECT_FIRST  = 12'hFDB;
  localparam logic [11:0] INDIRECT_LAST   = 12'hFEF;
  localparam logic [7:0]  INDIRECT_VALUE  = 8'h00;
  // program counter step to the next word
  localparam logic [20:0] PC_STEP         = 21'h00_0002;
  // state encoding, gray along idle -> second cycle -> idle
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CALL = 2'b01,
    ST_MOVE = 2'b10
  } state_t;
endpackage
`default_nettype wire

// [tb.sv]
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk   = 1'b0;      // 40 MHz system clock
  logic        rst_b = 1'b0;      // async reset, active low
  logic        en    = 1'b0;      // instruction cycle strobe
  logic [15:0] instr = 16'h0000;  // fetched word
  logic [20:0] pc    = 21'h00_0000;
  logic [7:0]  w     = 8'h00;
  logic [7:0]  lh    = 8'h00;
  logic [7:0]  lu    = 8'h00;
  logic [7:0]  rdata = 8'h00;     // data memory read byte
  logic [11:0] sp    = 12'h000;   // software stack pointer
  logic        push, pcld, flush, rd, wr, busy;
  logic [20:0] paddr, pcval;
  logic [11:0] maddr;
  logic [7:0]  wdata;
  int          err_total  = 0;
  int          num_checks = 0;
  // clock toggles every half period
  always #12.5 clk = ~clk;
  xcall_move xcall_move_i (.SYS_CLK_IN(clk), .RST_B_IN(rst_b), .CYCLE_EN_IN(en),
    .INSTR_IN(instr), .PC_IN(pc), .WORKING_REG_IN(w), .LATCH_HIGH_IN(lh),
    .LATCH_UPPER_IN(lu), .SOFT_SP_IN(sp), .MEM_RDATA_IN(rdata), .PUSH_OUT(push),
    .PUSH_ADDR_OUT(paddr), .PC_LOAD_OUT(pcld), .PC_VALUE_OUT(pcval), .FLUSH_OUT(flush),
    .MEM_ADDR_OUT(maddr), .MEM_RD_OUT(rd), .MEM_WR_OUT(wr), .MEM_WDATA_OUT(wdata),
    .BUSY_OUT(busy));
  // case-equality compare so unknowns never match
  task chk(input string nm, input logic [20:0] seen, input logic [20:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one enabled edge with a word; returns at the falling edge just after it,
  // while the one-clock pulses that the word caused still stand
  task issue(input logic [15:0] word);
    @(negedge clk);
    en    = 1'b1;
    instr = word;
    @(negedge clk);
    en    = 1'b0;
  endtask
  // computed call, upper latch bits above 4:0 must be dropped
  task run_call;
    pc = 21'h00_01F0;
    w  = 8'h06;
    lh = 8'h10;
    lu = 8'hE1;
    issue(16'h0014);
    chk("push", push, 1'b1);
    chk("push_addr", paddr, 21'h00_01F2);
    chk("pc_load", pcld, 1'b1);
    chk("pc_value", pcval, 21'h01_1006);
    chk("busy", busy, 1'b1);
    chk("flush_early", flush, 1'b0);
    chk("call_rd", rd, 1'b0);
    // a clock without enable keeps the call in its first cycle
    @(negedge clk);
    chk("push_once", push, 1'b0);
    chk("busy_hold", busy, 1'b1);
    // a call opcode in the nop cycle must not start again
    issue(16'h0014);
    chk("flush", flush, 1'b1);
    chk("push_again", push, 1'b0);
    chk("load_again", pcld, 1'b0);
    chk("busy_end", busy, 1'b0);
  endtask
  // two-word move, source read then destination write; sa is the expected source
  task run_move(input logic [11:0] s, input logic [6:0] off, input logic [11:0] sa,
                input logic [11:0] dst, input logic [7:0] src, input logic [7:0] exp);
    sp    = s;
    rdata = src;
    issue({9'h1D6, off});
    chk("rd", rd, 1'b1);
    chk("src_addr", maddr, sa);
    chk("wr_early", wr, 1'b0);
    issue({4'hF, dst});
    chk("wr", wr, 1'b1);
    chk("dst_addr", maddr, dst);
    chk("wdata", wdata, exp);
    chk("move_busy", busy, 1'b0);
  endtask
  // malformed second word and foreign opcode give no action
  task run_refuse;
    issue({9'h1D6, 7'h01});
    chk("rd_first", rd, 1'b1);
    issue(16'hE123);
    chk("wr_bad", wr, 1'b0);
    chk("busy_bad", busy, 1'b0);
    issue(16'h0015);
    chk("push_other", push, 1'b0);
    chk("rd_other", rd, 1'b0);
    chk("busy_other", busy, 1'b0);
  endtask
  // reset in the middle of a call drops it; the next call starts clean
  task run_reset;
    issue(16'h0014);
    rst_b = 1'b0;
    @(negedge clk);
    chk("rst_busy", busy, 1'b0);
    chk("rst_pc_value", pcval, 21'h00_0000);
    rst_b = 1'b1;
    issue(16'h0014);
    chk("rst_push", push, 1'b1);
    chk("rst_flush", flush, 1'b0);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    rst_b = 1'b1;
    chk("busy_rst", busy, 1'b0);
    chk("push_rst", push, 1'b0);
    run_call;
    // destinations are plain data bytes, never counter low or stack top
    run_move(12'h080, 7'h05, 12'h085, 12'h123, 8'h33, 8'h33);
    run_move(12'hFC0, 7'h7F, 12'h03F, 12'hF00, 8'hA5, 8'hA5);
    run_move(12'hF80, 7'h7F, 12'hFFF, 12'h000, 8'h3C, 8'h3C);
    run_move(12'hFD0, 7'h0B, 12'hFDB, 12'h200, 8'h5A, 8'h00);
    run_move(12'hFE0, 7'h0F, 12'hFEF, 12'h201, 8'hC3, 8'h00);
    run_move(12'hFD0, 7'h0A, 12'hFDA, 12'h202, 8'h96, 8'h96);
    run_move(12'hFE0, 7'h10, 12'hFF0, 12'h203, 8'h69, 8'h69);
    run_refuse;
    run_reset;
    end_of_test;
  end
  // whole run is under fifty clocks, so 20 us is ample margin
  initial begin
    #20us;
    err_total++;
    end_of_test;
  end
endmodule
`default_nettype wire
